// ==== src/twms_pkg.sv ====
// Shared constants for the two-wire memory slave and its bus master.
// Assumes a single 100 MHz clock; the serial bus is open drain.
package twms_pkg;
  localparam logic [7:0]  TWMS_MAIN_ADDR_FIXED = 8'h00_A2;
  localparam logic [7:0]  TWMS_AUX_ADDR        = 8'h00_A0;
  localparam logic [7:0]  TWMS_OFF_TEMP_MSB    = 8'h00_60;
  localparam logic [7:0]  TWMS_OFF_TEMP_LSB    = 8'h00_61;
  localparam logic [7:0]  TWMS_OFF_STATUS      = 8'h00_6E;
  localparam logic [7:0]  TWMS_OFF_ALARM       = 8'h00_70;
  localparam logic [7:0]  TWMS_OFF_MAIN_ADDR   = 8'h00_8C;
  localparam int          TWMS_RDY_BIT         = 0;
  localparam int          TWMS_VLO_BIT         = 4;
  localparam int          TWMS_PAGE_BYTES      = 8;
  localparam int          TWMS_CLK_MHZ         = 100;
  localparam int          TWMS_NVW_TIME_US     = 10;
  localparam int          TWMS_NVW_CYCLES      = TWMS_NVW_TIME_US * TWMS_CLK_MHZ;
  localparam int          TWMS_FRAME_TIME_US   = 100;
  localparam int          TWMS_FRAME_CYCLES    = TWMS_FRAME_TIME_US * TWMS_CLK_MHZ;
  localparam int          TWMS_SCL_100K_DIV    = TWMS_CLK_MHZ * 1000 / 100 / 4;
  localparam int          TWMS_SCL_400K_DIV    = TWMS_CLK_MHZ * 1000 / 400 / 4;
endpackage : twms_pkg

// ==== src/twms_if.sv ====
// Open-drain two-wire bus between the slave and its master.
// Assumes both parties drive only low; the wire resolves here.
`timescale 1ns/1ns
interface twms_if;
  logic scl_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = ~scl_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport slave  (input scl, input sda, output sda_s_oe);
  modport master (input scl, input sda, output scl_oe, output sda_m_oe);
endinterface : twms_if

// ==== src/twms_slave.sv ====
// Two-wire memory slave: framing, addressing, page writes, reads, status.
// Assumes bus lines synchronous to ref_clk and power levels as inputs.
//
// Behaviour
// [R1] Falling data with clock high starts
// [R2] Rising data with clock high stops
// [R3] Standby after power-on, stop, completion
// [R4] Acknowledge received bytes on ninth clock
// [R5] Address byte shifted in MSB first
// [R6] Main address fixed or stored; auxiliary fixed
// [R7] Match acknowledges, direction picks read/write
// [R8] Mismatch: no acknowledge, back to idle
// [R9] Fixed address and auxiliary until recall
// [R10] Ready flag low once conversions start
// [R11] Supply-low flag set until first conversion
// [R12] Temperature stored per frame, paused on access
// [R13] Table step 2 degrees, 1 degree hysteresis; code: none rising, 2 degrees falling
// [R14] Write: memory address then data acknowledged
// [R15] Timed write cycle ignores the bus
// [R16] Page writes up to eight bytes
// [R17] Write address wraps within page
// [R18] Commit only on stop
// [R19] Polling acknowledged only after write finishes
// [R20] Pointer is last address plus one
// [R21] Current-address read sends byte at pointer
// [R22] Random read: dummy write then reread
// [R23] Sequential read continues while acknowledged
// [R24] Works at 100 and 400 kHz
`timescale 1ns/1ns
module twms_slave
  import twms_pkg::*;
#(
  parameter int NVW_CYCLES   = TWMS_NVW_CYCLES,
  parameter int FRAME_CYCLES = TWMS_FRAME_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  twms_if.slave            bus,
  input  wire logic        analog_por_level,
  input  wire logic        address_source_select,
  input  wire logic        aux_address_enable,
  input  wire logic        write_protect,
  input  wire logic [15:0] temp_sample,
  input  wire logic        vcc_low_sample,
  output logic      [7:0]  res0_setting,
  output logic      [7:0]  res1_setting,
  output logic             busy,
  output logic             standby
);
  import twms_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001, ST_ADDR = 6'b000010, ST_MEMA = 6'b000100,
    ST_WDAT = 6'b001000, ST_RDAT = 6'b010000, ST_NVW  = 6'b100000
  } twms_st_t;

  typedef struct packed {
    twms_st_t    st;
    logic        scl_d;
    logic        sda_d;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic        aux;
    logic        ack;
    logic        mack;
    logic        sda_oe;
    logic [7:0]  ptr;
    logic [7:0]  pbase;
    logic [7:0]  pmask;
    logic [2:0]  pidx;
    logic [7:0]  pdat0, pdat1, pdat2, pdat3, pdat4, pdat5, pdat6, pdat7;
    logic        recalled;
    logic        conv_seen;
    logic        vlo;
    logic [15:0] temp;
    logic [31:0] cnt;
    logic [7:0]  tidx;
    logic [7:0]  r0, r1;
  } twms_s_t;

  twms_s_t s_reg, s_next;
  logic [7:0] mem_main [0:255];
  logic [7:0] mem_aux  [0:255];
  logic [7:0] pdat [0:7];
  logic [7:0] main_addr, rd_byte, wa;
  logic       rise, fall, start_c, stop_c, match_main, match_aux;
  logic       commit;
  logic [6:0] t_half;

  assign pdat = '{s_reg.pdat0, s_reg.pdat1, s_reg.pdat2, s_reg.pdat3,
                  s_reg.pdat4, s_reg.pdat5, s_reg.pdat6, s_reg.pdat7};
  assign rise    = bus.scl & ~s_reg.scl_d;                                    // [R24]
  assign fall    = ~bus.scl & s_reg.scl_d;
  assign start_c = bus.scl & s_reg.scl_d & s_reg.sda_d & ~bus.sda;   // [R1]
  assign stop_c  = bus.scl & s_reg.scl_d & ~s_reg.sda_d & bus.sda;   // [R2]
  assign main_addr = (address_source_select && s_reg.recalled)
                     ? mem_main[TWMS_OFF_MAIN_ADDR] : TWMS_MAIN_ADDR_FIXED; // [R6] [R9]
  assign match_main = s_reg.sh[7:1] == main_addr[7:1];
  assign match_aux  = (s_reg.sh[7:1] == TWMS_AUX_ADDR[7:1]) &&
                      (aux_address_enable || !s_reg.recalled);                // [R9]

  always_comb begin
    unique case (s_reg.ptr)
      TWMS_OFF_TEMP_MSB: rd_byte = s_reg.temp[15:8];                          // [R12]
      TWMS_OFF_TEMP_LSB: rd_byte = s_reg.temp[7:0];
      TWMS_OFF_STATUS:   rd_byte = {7'h00, !s_reg.conv_seen};                 // [R10]
      TWMS_OFF_ALARM:    rd_byte = {3'h0, s_reg.vlo, 4'h0};                   // [R11]
      default:           rd_byte = s_reg.aux ? mem_aux[s_reg.ptr] : mem_main[s_reg.ptr];
    endcase
  end

  // Storage written only at commit; pending page bytes stay in the state.
  assign commit = (s_reg.st == ST_NVW) && (s_reg.cnt == 32'd1);
  always_ff @(posedge ref_clk) begin
    if (commit) begin
      for (int i = 0; i < TWMS_PAGE_BYTES; i++) begin
        if (s_reg.pmask[i]) begin
          if (s_reg.aux)
            mem_aux[{s_reg.pbase[7:3], 3'(i)}] <= pdat[i];                   // [R18]
          else
            mem_main[{s_reg.pbase[7:3], 3'(i)}] <= pdat[i];
        end
      end
    end
  end

  always_comb begin
    s_next       = s_reg;
    s_next.scl_d = bus.scl;
    s_next.sda_d = bus.sda;
    wa           = {s_reg.pbase[7:3], s_reg.pidx};                           // [R17]
    t_half       = 7'(s_reg.temp[15:9]);
    if (analog_por_level) begin
      s_next.recalled = 1'b1;
    end else begin
      s_next.recalled  = 1'b0;
      s_next.conv_seen = 1'b0;                                                // [R10]
    end
    // Conversion frame counter; pauses while the bus is mid-access.
    if (s_reg.recalled && (s_reg.st == ST_IDLE)) begin                        // [R12]
      if (s_reg.cnt >= 32'(FRAME_CYCLES - 1)) begin
        s_next.cnt       = 32'd0;
        s_next.conv_seen = 1'b1;
        s_next.temp      = temp_sample;
        s_next.vlo       = vcc_low_sample;                                    // [R11]
        // Hysteresis: index rises on reaching the next step, falls only once below the step under it.
        if (t_half > 7'(s_reg.tidx) || (t_half + 7'd1) < 7'(s_reg.tidx) ||
            (s_reg.temp[8] && t_half == 7'(s_reg.tidx)))                      // [R13]
          s_next.tidx = {1'b0, t_half};
        s_next.r0 = mem_main[8'h80 | {1'b0, s_next.tidx[6:0]}];
        s_next.r1 = mem_main[{1'b1, s_next.tidx[6:0]} ^ 8'h40];
      end else if (s_reg.st == ST_IDLE) begin
        s_next.cnt = s_reg.cnt + 32'd1;
      end
    end
    if (s_reg.st == ST_NVW) begin
      s_next.sda_oe = 1'b0;
      if (s_reg.cnt <= 32'd1) begin
        s_next.st  = ST_IDLE;                                                 // [R3]
        s_next.cnt = 32'd0;
      end else begin
        s_next.cnt = s_reg.cnt - 32'd1;                                       // [R15] [R19]
      end
    end else if (stop_c) begin
      s_next.sda_oe = 1'b0;
      if (s_reg.st == ST_WDAT && s_reg.pmask != 8'h00) begin
        s_next.st  = ST_NVW;                                                  // [R18]
        s_next.cnt = 32'(NVW_CYCLES);
      end else begin
        s_next.st = ST_IDLE;                                                  // [R2] [R3]
      end
    end else if (start_c) begin
      s_next.st     = ST_ADDR;                                                // [R1] [R22]
      s_next.bitn   = 4'd0;
      s_next.sda_oe = 1'b0;
      s_next.pmask  = 8'h00;                                                  // [R18]
    end else if (s_reg.st != ST_IDLE) begin
      if (rise) begin
        if (s_reg.bitn < 4'd8)
          s_next.sh = {s_reg.sh[6:0], bus.sda};                               // [R5]
        else
          s_next.mack = ~bus.sda;
        s_next.bitn = s_reg.bitn + 4'd1;
      end
      if (fall) begin
        if (s_reg.bitn == 4'd8) begin
          s_next.sda_oe = 1'b0;
          s_next.ack    = 1'b0;
          unique case (s_reg.st)
            ST_ADDR: begin
              if (match_main || match_aux) begin
                s_next.aux = !match_main;                                     // [R7]
                s_next.ack = 1'b1;
                if (s_reg.sh[0]) begin
                  s_next.st = ST_RDAT;
                end else begin
                  s_next.st = ST_MEMA;
                end
              end else begin
                s_next.st = ST_IDLE;                                          // [R8]
              end
            end
            ST_MEMA: begin
              // Protected part refuses the memory address, so no write can follow
              if (write_protect) begin
                s_next.st  = ST_IDLE;                                         // [R14]
              end else begin
                s_next.ptr   = s_reg.sh;                                      // [R22]
                s_next.pbase = s_reg.sh;
                s_next.pidx  = s_reg.sh[2:0];
                s_next.st    = ST_WDAT;
                s_next.ack   = 1'b1;                                          // [R14]
              end
            end
            ST_WDAT: begin
              for (int i = 0; i < TWMS_PAGE_BYTES; i++) begin
                if (3'(i) == s_reg.pidx) begin
                  s_next.pmask[i] = 1'b1;
                end
              end
              s_next.pdat0 = (s_reg.pidx == 3'd0) ? s_reg.sh : s_reg.pdat0;  // [R16] [R17]
              s_next.pdat1 = (s_reg.pidx == 3'd1) ? s_reg.sh : s_reg.pdat1;
              s_next.pdat2 = (s_reg.pidx == 3'd2) ? s_reg.sh : s_reg.pdat2;
              s_next.pdat3 = (s_reg.pidx == 3'd3) ? s_reg.sh : s_reg.pdat3;
              s_next.pdat4 = (s_reg.pidx == 3'd4) ? s_reg.sh : s_reg.pdat4;
              s_next.pdat5 = (s_reg.pidx == 3'd5) ? s_reg.sh : s_reg.pdat5;
              s_next.pdat6 = (s_reg.pidx == 3'd6) ? s_reg.sh : s_reg.pdat6;
              s_next.pdat7 = (s_reg.pidx == 3'd7) ? s_reg.sh : s_reg.pdat7;
              s_next.ptr   = wa + 8'd1;                                       // [R20]
              s_next.pidx  = s_reg.pidx + 3'd1;
              s_next.ack   = 1'b1;
            end
            default: ;
          endcase
          s_next.sda_oe = s_next.ack;                                         // [R4] [R7]
        end else if (s_reg.bitn == 4'd9) begin
          s_next.bitn   = 4'd0;
          s_next.sda_oe = 1'b0;
          if (s_reg.st == ST_RDAT) begin
            if (s_reg.mack == 1'b0 && s_reg.ack == 1'b0) begin
              s_next.st = ST_IDLE;                                            // [R23]
            end else begin
              s_next.sh     = rd_byte;                                        // [R21]
              s_next.ptr    = s_reg.ptr + 8'd1;                               // [R20] [R23]
              s_next.sda_oe = ~rd_byte[7];
              s_next.ack    = 1'b0;
              s_next.mack   = 1'b1;
            end
          end
        end else if (s_reg.st == ST_RDAT && s_reg.bitn < 4'd8) begin
          s_next.sda_oe = ~s_reg.sh[3'd7 - s_reg.bitn[2:0]];
        end
      end
      if (s_reg.st == ST_RDAT && rise && s_reg.bitn < 4'd8)
        s_next.sh = s_reg.sh;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg     <= '0;
      s_reg.st  <= ST_IDLE;                                                   // [R3]
      s_reg.scl_d <= 1'b1;
      s_reg.sda_d <= 1'b1;
      s_reg.vlo <= 1'b1;                                                      // [R11]
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.sda_s_oe = s_reg.sda_oe;
  assign res0_setting = s_reg.r0;
  assign res1_setting = s_reg.r1;
  assign busy         = s_reg.st == ST_NVW;
  assign standby      = s_reg.st == ST_IDLE;
endmodule : twms_slave

// ==== src/twms_master.sv ====
// Bus master end: one byte-level transaction per command.
// Assumes a user that waits for done before the next command.
`timescale 1ns/1ns
module twms_master
  import twms_pkg::*;
#(
  parameter int DIV = TWMS_SCL_100K_DIV
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  twms_if.master          bus,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_op,
  input  wire logic [7:0] cmd_data,
  input  wire logic       cmd_last,
  output logic            cmd_ready,
  output logic [7:0]      rsp_data,
  output logic            rsp_ack,
  output logic            done
);
  import twms_pkg::*;
  // Ops: 0 start, 1 write byte, 2 read byte (ack unless cmd_last), 3 stop.
  typedef enum logic [2:0] {M_IDLE = 3'b001, M_RUN = 3'b010, M_DONE = 3'b100} twms_m_t;
  typedef struct packed {
    twms_m_t    st;
    logic [1:0] op;
    logic [3:0] step;
    logic [1:0] ph;
    logic [15:0] div;
    logic [8:0] sh;
    logic       scl_oe;
    logic       sda_oe;
    logic [7:0] rd;
    logic       ack;
  } twms_ms_t;
  twms_ms_t m_reg, m_next;
  logic tick;
  assign tick = m_reg.div == 16'(DIV - 1);

  always_comb begin
    m_next = m_reg;
    m_next.div = tick ? 16'h0000 : m_reg.div + 16'h0001;
    unique case (m_reg.st)
      M_IDLE: if (cmd_valid) begin
        m_next.st   = M_RUN;                                                  // [R1] [R22]
        m_next.op   = cmd_op;
        m_next.step = 4'd0;
        m_next.ph   = 2'd0;
        m_next.sh   = (cmd_op == 2'd2) ? {8'hFF, cmd_last} : {cmd_data, 1'b1}; // [R5] [R23]
      end
      M_RUN: if (tick) begin
        m_next.ph = m_reg.ph + 2'd1;
        if (m_reg.op == 2'd0 || m_reg.op == 2'd3) begin
          unique case (m_reg.ph)
            2'd0: begin m_next.sda_oe = (m_reg.op == 2'd3); m_next.scl_oe = 1'b1; end
            2'd1: m_next.scl_oe = 1'b0;
            2'd2: m_next.sda_oe = (m_reg.op == 2'd0);                         // [R1] [R2]
            // A start leaves the clock low so the first data bit cannot look like a stop
            default: begin m_next.scl_oe = (m_reg.op == 2'd0); m_next.st = M_DONE; end
          endcase
        end else begin
          unique case (m_reg.ph)
            2'd0: m_next.sda_oe = ~m_reg.sh[8];                               // [R1]
            2'd1: m_next.scl_oe = 1'b0;
            2'd2: begin
              m_next.rd  = {m_reg.rd[6:0], bus.sda};
              m_next.ack = ~bus.sda;                                          // [R19]
            end
            default: begin
              m_next.scl_oe = 1'b1;
              m_next.sh     = {m_reg.sh[7:0], 1'b1};
              m_next.step   = m_reg.step + 4'd1;
              if (m_reg.step == 4'd8) begin
                m_next.st = M_DONE;
                m_next.sda_oe = 1'b0;
                if (m_reg.op == 2'd2) m_next.rd = m_reg.rd;
              end
            end
          endcase
          if (m_reg.ph == 2'd2 && m_reg.step == 4'd8 && m_reg.op == 2'd2)
            m_next.rd = m_reg.rd;                                             // [R21] [R23]
        end
      end
      default: m_next.st = M_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_reg    <= '0;
      m_reg.st <= M_IDLE;
    end else begin
      m_reg <= m_next;
    end
  end

  assign bus.scl_oe   = m_reg.scl_oe;
  assign bus.sda_m_oe = m_reg.sda_oe;
  assign cmd_ready    = m_reg.st == M_IDLE;
  assign rsp_data     = m_reg.rd;
  assign rsp_ack      = m_reg.ack;
  assign done         = m_reg.st == M_DONE;
endmodule : twms_master

// ==== verif/twms_checker.sv ====
// Bus protocol checker for the open-drain link between slave and master.
// Assumes the wire levels resolved in the interface and one clock domain.
`timescale 1ns/1ns
module twms_checker
  import twms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       first;
    logic       wr;
    logic [3:0] bit_idx;
    logic [7:0] addr;
  } twms_chk_t;
  twms_chk_t st_reg;
  twms_chk_t st_next;
  logic      start_ev;
  logic      stop_ev;
  logic      mismatch;
  assign start_ev = scl && st_reg.scl && st_reg.sda && !sda;
  assign stop_ev  = scl && st_reg.scl && !st_reg.sda && sda;
  assign mismatch = (st_reg.addr[7:1] != TWMS_MAIN_ADDR_FIXED[7:1])
                 && (st_reg.addr[7:1] != TWMS_AUX_ADDR[7:1]);
  // Bit index starts at F after a start, so the first clock fall lands on bit 0
  always_comb begin
    st_next     = st_reg;
    st_next.scl = scl;
    st_next.sda = sda;
    if (scl && !st_reg.scl && st_reg.bit_idx < 4'h8) begin
      st_next.addr = {st_reg.addr[6:0], sda};
    end
    if (!scl && st_reg.scl) begin
      st_next.bit_idx = (st_reg.bit_idx == 4'h8) ? 4'h0 : st_reg.bit_idx + 4'h1;
      if (st_reg.bit_idx == 4'h8 && st_reg.first) begin
        st_next.first = 1'b0;
        st_next.wr    = ~st_reg.addr[0];
      end
    end
    if (start_ev) begin
      st_next.first   = 1'b1;
      st_next.wr      = 1'b1;
      st_next.bit_idx = 4'hF;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{scl: 1'b1, sda: 1'b1, first: 1'b0, wr: 1'b1, bit_idx: 4'hF, addr: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_slave_scl_low: assert property (scl && st_reg.scl |-> $stable(sda_s_oe))
    else $error("slave changed data while clock high");
  a_start_by_master: assert property (start_ev |-> sda_m_oe && !$past(sda_s_oe))
    else $error("start not made by master");
  a_stop_by_master: assert property (stop_ev |-> $past(sda_m_oe) && !sda_s_oe)
    else $error("stop not made by master");
  a_idle_after_stop: assert property (stop_ev |-> !sda_s_oe [*8])
    else $error("slave drives after stop");
  a_ack_held: assert property ($rose(scl) && sda_s_oe |-> !sda [*4])
    else $error("acknowledge low not held");
  a_addr_no_drive: assert property (scl && st_reg.first && st_reg.bit_idx < 4'h8 |-> !sda_s_oe)
    else $error("slave drives during address bits");
  a_mismatch_nak: assert property (scl && st_reg.first && st_reg.bit_idx == 4'h8 && mismatch
      |-> !sda_s_oe)
    else $error("foreign address acknowledged");
  a_write_no_drive: assert property (scl && !st_reg.first && st_reg.wr
      && st_reg.bit_idx < 4'h8 |-> !sda_s_oe)
    else $error("slave drives during written data bits");
  a_read_ack_free: assert property (scl && !st_reg.first && !st_reg.wr
      && st_reg.bit_idx == 4'h8 |-> !sda_s_oe)
    else $error("slave holds line in master acknowledge slot");
endmodule : twms_checker

// ==== verif/twms_slave_test.sv ====
// Self-checking bench: master and slave joined on one bus, checker beside it.
// Assumes the master's command handshake; write time twice the default, short frame time.
`timescale 1ns/1ns
module twms_slave_test;
  import twms_pkg::*;
  localparam logic [7:0] WR = TWMS_MAIN_ADDR_FIXED;
  localparam logic [7:0] RD = TWMS_MAIN_ADDR_FIXED | 8'h01;
  logic        ref_clk, rst_n, cmd_valid, cmd_last, cmd_ready, rsp_ack, done, busy, standby;
  logic        por_ok, src_sel, aux_en, wp, vlo;
  logic [1:0]  cmd_op;
  logic [7:0]  cmd_data, rsp_data, res0, res1, v;
  logic [15:0] temp;
  int          err_total, checks;
  twms_if bus ();
  twms_slave #(.NVW_CYCLES(2000), .FRAME_CYCLES(200)) u_twms_slave (.ref_clk(ref_clk),
    .rst_n(rst_n), .bus(bus), .analog_por_level(por_ok), .address_source_select(src_sel),
    .aux_address_enable(aux_en), .write_protect(wp), .temp_sample(temp),
    .vcc_low_sample(vlo), .res0_setting(res0), .res1_setting(res1), .busy(busy),
    .standby(standby));
  twms_master #(.DIV(8)) u_twms_master (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_last(cmd_last),
    .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_ack(rsp_ack), .done(done));
  twms_checker u_twms_checker (.ref_clk(ref_clk), .rst_n(rst_n), .scl_oe(bus.scl_oe),
    .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe), .scl(bus.scl), .sda(bus.sda));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [1:0] op, input logic [7:0] d, input logic last);
    int n;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_data  = d;
    cmd_last  = last;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      err_total++;
      conclude();
    end
  endtask : cmd
  task automatic sta();
    cmd(2'h0, 8'h00, 1'b0);
  endtask : sta
  task automatic stp();
    cmd(2'h3, 8'h00, 1'b0);
  endtask : stp
  task automatic wb(input logic [7:0] d, input logic ack);
    cmd(2'h1, d, 1'b0);
    chk({7'h00, rsp_ack}, {7'h00, ack});
  endtask : wb
  task automatic rb(input logic last, output logic [7:0] d);
    cmd(2'h2, 8'h00, last);
    d = rsp_data;
  endtask : rb
  // Dummy write sets the pointer, then a repeated start reads from it
  task automatic seek(input logic [7:0] a);
    sta();
    wb(WR, 1'b1);
    wb(a, 1'b1);
    sta();
    wb(RD, 1'b1);
  endtask : seek
  task automatic rd_at(input logic [7:0] a, output logic [7:0] d);
    seek(a);
    rb(1'b1, d);
    stp();
  endtask : rd_at
  // Bounded: each attempt costs a whole address byte on the bus
  task automatic poll();
    int i;
    i = 0;
    do begin
      sta();
      cmd(2'h1, WR, 1'b0);
      i++;
    end while (rsp_ack !== 1'b1 && i < 40);
    stp();
    chk({7'h00, busy}, 8'h00);
  endtask : poll
  task automatic t_power();
    chk({7'h00, standby}, 8'h01);
    rd_at(TWMS_OFF_STATUS, v);
    chk(v & 8'h01, 8'h01);
    rd_at(TWMS_OFF_ALARM, v);
    chk(v & 8'h10, 8'h10);
    @(negedge ref_clk) por_ok = 1'b1;
    repeat (3000) @(negedge ref_clk);
    rd_at(TWMS_OFF_STATUS, v);
    chk(v & 8'h01, 8'h00);
    rd_at(TWMS_OFF_ALARM, v);
    chk(v & 8'h10, 8'h00);
    seek(TWMS_OFF_TEMP_MSB);
    rb(1'b0, v);
    chk(v, 8'h12);
    rb(1'b1, v);
    chk(v, 8'h34);
    stp();
    @(negedge ref_clk) por_ok = 1'b0;
    repeat (20) @(negedge ref_clk);
    rd_at(TWMS_OFF_STATUS, v);
    chk(v & 8'h01, 8'h01);
    @(negedge ref_clk) por_ok = 1'b1;
    repeat (3000) @(negedge ref_clk);
  endtask : t_power
  task automatic t_addr();
    logic [7:0] ad [4] = '{WR, TWMS_AUX_ADDR, 8'h44, 8'hA4};
    logic       ak [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    foreach (ad[i]) begin
      sta();
      wb(ad[i], ak[i]);
      stp();
    end
  endtask : t_addr
  task automatic t_write();
    sta();
    wb(WR, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'h5A, 1'b1);
    stp();
    chk({7'h00, busy}, 8'h01);
    sta();
    wb(WR, 1'b0);
    poll();
    sta();
    wb(WR, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'hC3, 1'b1);
    rd_at(8'h10, v);
    chk(v, 8'h5A);
    chk({7'h00, busy}, 8'h00);
  endtask : t_write
  task automatic t_page();
    int i;
    sta();
    wb(WR, 1'b1);
    wb(8'h06, 1'b1);
    for (i = 0; i < 10; i++) wb(8'hD0 + 8'(i), 1'b1);
    stp();
    poll();
    seek(8'hFF);
    rb(1'b0, v);
    for (i = 0; i < 6; i++) begin
      rb(i == 5, v);
      chk(v, 8'hD2 + 8'(i));
    end
    stp();
    sta();
    wb(RD, 1'b1);
    rb(1'b1, v);
    stp();
    chk(v, 8'hD8);
  endtask : t_page
  task automatic t_wp();
    @(negedge ref_clk) wp = 1'b1;
    sta();
    wb(WR, 1'b1);
    wb(8'h20, 1'b0);
    stp();
    chk({7'h00, busy}, 8'h00);
    @(negedge ref_clk) wp = 1'b0;
  endtask : t_wp
  task automatic conclude();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    err_total = 0;
    checks    = 0;
    {rst_n, cmd_valid, cmd_last, por_ok, src_sel, wp} = 6'h00;
    {aux_en, vlo} = 2'h3;
    cmd_op   = 2'h0;
    cmd_data = 8'h00;
    temp     = 16'h1234;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk) vlo = 1'b0;
    t_power();
    t_addr();
    t_write();
    t_page();
    t_wp();
    conclude();
  end
  // Whole sequence needs well under half of this span
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
endmodule : twms_slave_test
